// ===== hdl/cdob_bridge.sv
// request routing, ordering and write-visibility logic of the bridge
`timescale 1ns/100ps
module cdob_bridge (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  // configuration
  input  wire logic                        ppw_all_mode,
  input  wire logic                        np_all_default,
  input  wire logic                        func_header,
  input  wire logic                        end_of_chain,
  input  wire logic [cdob_pkg::RANGES*cdob_pkg::ADDR_W-1:0] rng_base,
  input  wire logic [cdob_pkg::RANGES*cdob_pkg::ADDR_W-1:0] rng_limit,
  input  wire logic [cdob_pkg::RANGES-1:0] rng_en,
  input  wire logic [cdob_pkg::ADDR_W-1:0] leg_base,
  input  wire logic [cdob_pkg::ADDR_W-1:0] leg_limit,
  input  wire logic [cdob_pkg::ADDR_W-1:0] sec_base,
  input  wire logic [cdob_pkg::ADDR_W-1:0] sec_limit,
  // host request in
  input  wire logic                        hreq_valid,
  input  wire logic [cdob_pkg::ADDR_W-1:0] hreq_addr,
  input  wire logic                        hreq_posted,
  input  wire logic                        hreq_isoc,
  input  wire logic [cdob_pkg::SEQ_W-1:0]  hreq_seq,
  output logic                             hreq_ready,
  // downstream request out
  output logic                             dreq_valid,
  output logic [cdob_pkg::ADDR_W-1:0]      dreq_addr,
  output logic                             dreq_default_route,
  output logic                             dreq_posted,
  output logic                             dreq_isoc,
  output logic [cdob_pkg::SEQ_W-1:0]       dreq_seq_tag,
  // completion of a downstream nonposted request
  input  wire logic                        dcpl_valid,
  input  wire logic                        dcpl_legacy,
  // downstream response path
  input  wire logic                        drsp_valid,
  input  wire logic                        drsp_ppw,
  input  wire logic                        drsp_isoc,
  input  wire logic                        posted_stalled,
  output logic                             rsp_valid,
  output logic                             pass_posted_write_flag,
  output logic                             rsp_isoc,
  output logic                             rsp_overtake,
  // upstream peer requests
  input  wire logic                        p2p_valid,
  output logic                             p2p_ack,
  // buffer-release nop
  input  wire logic                        nop_req,
  output logic                             nop_valid,
  output logic                             nop_isoc,
  // primary side of the bridge
  input  wire logic                        pri_valid,
  input  wire logic [cdob_pkg::ADDR_W-1:0] pri_addr,
  input  wire logic                        pri_default_route,
  input  wire logic                        pri_nonposted,
  input  wire logic                        pri_isoc,
  input  wire logic                        pri_cfg,
  input  wire logic [cdob_pkg::BUS_W-1:0]  pri_cfg_bus,
  output logic                             pri_claim,
  output logic                             cpl_isoc,
  // secondary side of the bridge
  input  wire logic                        sec_valid,
  input  wire logic [cdob_pkg::ADDR_W-1:0] sec_addr,
  input  wire logic                        sec_posted,
  input  wire logic                        sec_isoc,
  input  wire logic                        sec_from_legacy,
  output logic                             sec_ready,
  output logic                             fwd_valid,
  output logic [cdob_pkg::ADDR_W-1:0]      fwd_addr,
  output logic                             fwd_posted,
  output logic                             fwd_isoc,
  // flush tracking
  output logic                             flush_valid,
  input  wire logic                        flush_rsp,
  output logic                             write_visible_out
);

  typedef struct packed {
    logic                        hreq_ready;
    logic                        dreq_valid;
    logic [cdob_pkg::ADDR_W-1:0] dreq_addr;
    logic                        dreq_dflt;
    logic                        dreq_posted;
    logic                        dreq_isoc;
    logic [cdob_pkg::SEQ_W-1:0]  dreq_seq;
    logic                        leg_out;
    logic [cdob_pkg::NP_CNT_W-1:0] np_cnt;
    logic                        rsp_valid;
    logic                        rsp_ppw;
    logic                        rsp_isoc;
    logic                        rsp_ovt;
    logic                        p2p_ack;
    logic                        nop_valid;
    logic                        nop_isoc;
    logic                        pri_claim;
    logic                        cpl_isoc;
    logic                        sec_ready;
    logic                        fwd_valid;
    logic [cdob_pkg::ADDR_W-1:0] fwd_addr;
    logic                        fwd_posted;
    logic                        fwd_isoc;
    logic                        flush_valid;
    logic [cdob_pkg::FLUSH_W-1:0] flush_cnt;
    logic                        wvis;
  } cdob_state_t;

  cdob_state_t st_q;
  cdob_state_t st_d;

  logic rst_s1_q;
  logic rst_n_q;
  logic pos_hit;
  logic leg_hit;
  logic sec_hit;
  logic take;
  logic tgt_leg;
  logic is_np;
  logic np_done;
  logic leg_done;
  logic fl_issue;

  // reset released through two flops; asserts at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  cdob_range_match u_pos (
    .addr       (hreq_addr),
    .base_flat  (rng_base),
    .limit_flat (rng_limit),
    .en         (rng_en),
    .hit        (pos_hit)
  );

  // compat chain own range, also the legacy memory range
  assign leg_hit = hreq_addr >= leg_base && hreq_addr <= leg_limit;
  assign sec_hit = sec_addr >= sec_base && sec_addr <= sec_limit;

  // miss on every range goes default-routed
  assign tgt_leg = !(pos_hit || leg_hit) || leg_hit;
  assign take    = hreq_valid && st_q.hreq_ready;

  // nonposted channel for legacy-range requests, or with np_all_default for default-routed ones instead
  always_comb begin
    is_np = !hreq_posted;
    if (np_all_default && !(pos_hit || leg_hit))
      is_np = 1'b1;
    if (!np_all_default && leg_hit)
      is_np = 1'b1;
  end

  assign np_done  = dcpl_valid && !dcpl_legacy && st_q.np_cnt != '0;
  assign leg_done = dcpl_valid && dcpl_legacy && st_q.leg_out;
  assign fl_issue = sec_valid && st_q.sec_ready && sec_posted &&
                    sec_from_legacy &&
                    (func_header || !sec_hit);

  always_comb begin
    st_d = st_q;

    // host to chain request
    st_d.dreq_valid = take;
    if (take) begin
      st_d.dreq_addr = hreq_addr;
      // hits of positive ranges leave the flag clear
      st_d.dreq_dflt = !(pos_hit || leg_hit);
      st_d.dreq_posted = !is_np;
      st_d.dreq_isoc = hreq_isoc;
      st_d.dreq_seq  = hreq_seq;
      if (tgt_leg)
        st_d.dreq_seq = cdob_pkg::SEQ_LEGACY;
    end

    // outstanding accounting, legacy never mixed with others
    if (leg_done)
      st_d.leg_out = 1'b0;
    if (np_done)
      st_d.np_cnt = st_q.np_cnt - 1'b1;
    if (take && is_np && tgt_leg)
      st_d.leg_out = 1'b1;
    if (take && is_np && !tgt_leg)
      st_d.np_cnt = st_d.np_cnt + 1'b1;
    // held request other than a nonposted legacy one may join others
    // a nonposted legacy request only ever sees ready with nothing outstanding
    st_d.hreq_ready = !st_d.leg_out && st_d.np_cnt == '0 ||
                      !st_d.leg_out && !take &&
                      st_d.np_cnt != cdob_pkg::NP_TOP &&
                      hreq_valid && !(is_np && tgt_leg);

    // peer requests acknowledged regardless of legacy state
    st_d.p2p_ack = p2p_valid;

    // downstream responses
    st_d.rsp_valid = drsp_valid;
    // mode sets the flag on every response
    st_d.rsp_ppw  = drsp_ppw || ppw_all_mode;
    st_d.rsp_isoc = drsp_isoc;
    // flagged response overtakes stalled posted traffic
    st_d.rsp_ovt  = drsp_valid && (drsp_ppw || ppw_all_mode) &&
                    posted_stalled;

    st_d.nop_valid = nop_req;
    st_d.nop_isoc  = cdob_pkg::NOP_ISOC;

    // primary claim, no unit tag involved
    st_d.pri_claim = pri_valid &&
                     (pri_default_route || end_of_chain ||
                      // function header answers config bus zero
                      (func_header && pri_cfg &&
                       pri_cfg_bus == cdob_pkg::CFG_BUS_ZERO));
    // flagged nonposted request yields flagged response
    st_d.cpl_isoc = pri_valid && pri_nonposted && pri_isoc;

    st_d.fwd_valid = sec_valid && st_q.sec_ready &&
                     (func_header || !sec_hit);
    if (sec_valid && st_q.sec_ready) begin
      st_d.fwd_addr   = sec_addr;
      st_d.fwd_posted = sec_posted;
      st_d.fwd_isoc   = sec_isoc;
    end

    // flush after each forwarded legacy posted write
    st_d.flush_valid = fl_issue;
    // counter; issue and response together cancel
    // a stray answer with nothing outstanding must not swallow an issue
    if (fl_issue && !(flush_rsp && st_q.flush_cnt != '0))
      st_d.flush_cnt = st_q.flush_cnt + 1'b1;
    else if (!fl_issue && flush_rsp && st_q.flush_cnt != '0)
      st_d.flush_cnt = st_q.flush_cnt - 1'b1;
    // stall the secondary side before the counter could wrap
    st_d.sec_ready = st_d.flush_cnt < cdob_pkg::FLUSH_TOP - 1'b1;
    // visible only with no flush outstanding
    st_d.wvis = st_d.flush_cnt == '0 && !fl_issue;
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q           <= '0;
      st_q.np_cnt    <= cdob_pkg::NP_CNT_RST;
      st_q.flush_cnt <= cdob_pkg::FLUSH_RST;
      st_q.dreq_seq  <= cdob_pkg::SEQ_RST;
      st_q.hreq_ready <= 1'b1;
      st_q.sec_ready <= 1'b1;
      st_q.wvis      <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign hreq_ready             = st_q.hreq_ready;
  assign dreq_valid             = st_q.dreq_valid;
  assign dreq_addr              = st_q.dreq_addr;
  assign dreq_default_route     = st_q.dreq_dflt;
  assign dreq_posted            = st_q.dreq_posted;
  assign dreq_isoc              = st_q.dreq_isoc;
  assign dreq_seq_tag           = st_q.dreq_seq;
  assign rsp_valid              = st_q.rsp_valid;
  assign pass_posted_write_flag = st_q.rsp_ppw;
  assign rsp_isoc               = st_q.rsp_isoc;
  assign rsp_overtake           = st_q.rsp_ovt;
  assign p2p_ack                = st_q.p2p_ack;
  assign nop_valid              = st_q.nop_valid;
  // zero flag on nops, registered like every output
  assign nop_isoc               = st_q.nop_isoc;
  assign pri_claim              = st_q.pri_claim;
  assign cpl_isoc               = st_q.cpl_isoc;
  assign sec_ready              = st_q.sec_ready;
  assign fwd_valid              = st_q.fwd_valid;
  assign fwd_addr               = st_q.fwd_addr;
  assign fwd_posted             = st_q.fwd_posted;
  assign fwd_isoc               = st_q.fwd_isoc;
  assign flush_valid            = st_q.flush_valid;
  assign write_visible_out      = st_q.wvis;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  ppw_mode_a: assert property (
    ppw_all_mode && drsp_valid |=> rsp_valid && pass_posted_write_flag)
    else $error("response lost forced pass flag");
  overtake_a: assert property (
    drsp_valid && drsp_ppw && posted_stalled |=> rsp_overtake)
    else $error("flagged response did not overtake");
  nop_flag_a: assert property (
    nop_valid |-> !nop_isoc)
    else $error("nop carried low-latency flag");
  isoc_fwd_a: assert property (
    take |=> dreq_isoc == $past(hreq_isoc))
    else $error("low-latency flag altered");
  cpl_isoc_a: assert property (
    pri_valid && pri_nonposted && pri_isoc |=> cpl_isoc)
    else $error("response lost low-latency flag");
  no_mix_a: assert property (
    !(st_q.leg_out && st_q.np_cnt != '0))
    else $error("legacy and other requests mixed");
  seq_zero_a: assert property (
    take && tgt_leg |=> dreq_seq_tag == cdob_pkg::SEQ_LEGACY)
    else $error("legacy request tag not zero");
  dflt_flag_a: assert property (
    take && !pos_hit && !leg_hit |=> dreq_default_route)
    else $error("range miss without default flag");
  claim_a: assert property (
    pri_valid && pri_default_route |=> pri_claim)
    else $error("default-routed request not claimed");
  flush_a: assert property (
    fl_issue |=> flush_valid ##1 (!write_visible_out || flush_rsp))
    else $error("flush not issued after legacy write");
  wvis_a: assert property (
    st_q.flush_cnt != '0 |-> !write_visible_out)
    else $error("visible with flush outstanding");
  peer_a: assert property (
    p2p_valid && st_q.leg_out |=> p2p_ack)
    else $error("peer request starved");
  np_chan_a: assert property (
    take && np_all_default && !pos_hit && !leg_hit |=> !dreq_posted)
    else $error("default-routed request left posted");
  leg_np_a: assert property (
    take && !np_all_default && leg_hit |=> !dreq_posted)
    else $error("legacy-range request left posted");
  dflt_clr_a: assert property (
    take && (pos_hit || leg_hit) |=> !dreq_default_route)
    else $error("range hit sent default-routed");
  eoc_claim_a: assert property (
    pri_valid && end_of_chain |=> pri_claim)
    else $error("end-of-chain request not claimed");
  cfg_bus_a: assert property (
    pri_valid && func_header && pri_cfg &&
    pri_cfg_bus == cdob_pkg::CFG_BUS_ZERO |=> pri_claim)
    else $error("bus zero configuration not claimed");
  fwd_sec_a: assert property (
    sec_valid && sec_ready && (func_header || !sec_hit) |=> fwd_valid)
    else $error("secondary request not forwarded");

  legacy_c: cover property (take && tgt_leg ##[1:20] leg_done);
  flush_c:  cover property (fl_issue ##[1:20] write_visible_out);
  ovt_c:    cover property (rsp_overtake);
  np_two_c: cover property (st_q.np_cnt == 3'h2);

endmodule : cdob_bridge

// ===== hdl/cdob_pkg.sv
// constants for the compatibility decode and ordering bridge
package cdob_pkg;

  localparam int unsigned ADDR_W     = 40;
  localparam int unsigned RANGES     = 4;
  localparam int unsigned SEQ_W      = 4;
  localparam int unsigned BUS_W      = 8;
  localparam int unsigned NP_MAX     = 4;
  localparam int unsigned NP_CNT_W   = 3;
  localparam int unsigned FLUSH_MAX  = 7;
  localparam int unsigned FLUSH_W    = 3;

  localparam logic [SEQ_W-1:0]    SEQ_LEGACY   = 4'h0;
  localparam logic [BUS_W-1:0]    CFG_BUS_ZERO = 8'h00;
  localparam logic                NOP_ISOC     = 1'b0;
  localparam logic [NP_CNT_W-1:0] NP_CNT_RST   = 3'h0;
  localparam logic [FLUSH_W-1:0]  FLUSH_RST    = 3'h0;
  localparam logic [FLUSH_W-1:0]  FLUSH_TOP    = 3'h7;
  localparam logic [NP_CNT_W-1:0] NP_TOP       = 3'h4;
  localparam logic [SEQ_W-1:0]    SEQ_RST      = 4'h0;

endpackage : cdob_pkg

// ===== hdl/cdob_range_match.sv
// positive-decode range comparator bank
`timescale 1ns/100ps
module cdob_range_match #(
  parameter int unsigned N = cdob_pkg::RANGES,
  parameter int unsigned W = cdob_pkg::ADDR_W
) (
  // address under test
  input  wire logic [W-1:0]   addr,
  // range table, entry i in slice i
  input  wire logic [N*W-1:0] base_flat,
  input  wire logic [N*W-1:0] limit_flat,
  input  wire logic [N-1:0]   en,
  // result
  output logic                hit
);
  logic [N-1:0] hits;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_rng
      // limits are inclusive
      assign hits[gi] = en[gi] &&
                        addr >= base_flat[gi*W +: W] &&
                        addr <= limit_flat[gi*W +: W];
    end
  endgenerate

  assign hit = |hits;

endmodule : cdob_range_match

// ===== bench/cdob_partner.sv
// far-side chain model: completes nonposted requests, answers flushes
`timescale 1ns/100ps
module cdob_partner (
  // clock, reset and pace
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        slow,
  // traffic seen on the chain
  input  wire logic                        dreq_valid,
  input  wire logic                        dreq_posted,
  input  wire logic                        dreq_default_route,
  input  wire logic [cdob_pkg::ADDR_W-1:0] dreq_addr,
  input  wire logic [cdob_pkg::ADDR_W-1:0] leg_base,
  input  wire logic [cdob_pkg::ADDR_W-1:0] leg_limit,
  input  wire logic                        flush_valid,
  // answers
  output logic                             dcpl_valid,
  output logic                             dcpl_legacy,
  output logic                             flush_rsp
);
  int cyc;
  int np_due[$];
  bit np_leg[$];
  int fl_due[$];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc = 0;
      np_due.delete();
      np_leg.delete();
      fl_due.delete();
      dcpl_valid <= 1'b0;
      dcpl_legacy <= 1'b0;
      flush_rsp <= 1'b0;
    end else begin
      cyc++;
      dcpl_valid <= 1'b0;
      flush_rsp <= 1'b0;
      // qualifier carries no meaning between completions
      dcpl_legacy <= ~dcpl_legacy;
      if (dreq_valid && !dreq_posted) begin
        np_due.push_back(cyc + (slow ? 8 : 2));
        np_leg.push_back(dreq_default_route ||
                         (dreq_addr >= leg_base && dreq_addr <= leg_limit));
      end
      // slow pace lets several flushes pile up
      if (flush_valid) fl_due.push_back(cyc + (slow ? 30 : 2));
      if (np_due.size() > 0 && np_due[0] <= cyc) begin
        dcpl_valid <= 1'b1;
        dcpl_legacy <= np_leg[0];
        void'(np_due.pop_front());
        void'(np_leg.pop_front());
      end
      if (fl_due.size() > 0 && fl_due[0] <= cyc) begin
        flush_rsp <= 1'b1;
        void'(fl_due.pop_front());
      end
    end
  end
endmodule : cdob_partner

// ===== bench/testbench.sv
// self-checking bench for the routing and ordering bridge
`timescale 1ns/100ps
module testbench;
  localparam int AW = cdob_pkg::ADDR_W;
  localparam int RW = cdob_pkg::RANGES * AW;
  logic clk = 0, reset_n = 0, slow = 0;
  logic ppw_all_mode = 0, np_all_default = 0, func_header = 0;
  logic end_of_chain = 0, hreq_valid = 0, hreq_posted = 0, hreq_isoc = 0;
  logic [RW-1:0] rng_base = '0, rng_limit = '0;
  logic [cdob_pkg::RANGES-1:0] rng_en = '1;
  logic [AW-1:0] leg_base = 40'h00000c0000, leg_limit = 40'h00000fffff;
  logic [AW-1:0] sec_base = 40'h1000, sec_limit = 40'h1fff;
  logic [AW-1:0] hreq_addr = '0, pri_addr = '0, sec_addr = '0;
  logic [cdob_pkg::SEQ_W-1:0] hreq_seq = '0;
  logic drsp_valid = 0, drsp_ppw = 0, drsp_isoc = 0, posted_stalled = 0;
  logic p2p_valid = 0, nop_req = 0, pri_valid = 0, pri_default_route = 0;
  logic pri_nonposted = 0, pri_isoc = 0, pri_cfg = 0;
  logic [cdob_pkg::BUS_W-1:0] pri_cfg_bus = '0;
  logic sec_valid = 0, sec_posted = 0, sec_isoc = 0, sec_from_legacy = 0;
  logic hreq_ready, dreq_valid, dreq_default_route, dreq_posted, dreq_isoc;
  logic [AW-1:0] dreq_addr, fwd_addr;
  logic [cdob_pkg::SEQ_W-1:0] dreq_seq_tag;
  logic dcpl_valid, dcpl_legacy, rsp_valid, pass_posted_write_flag;
  logic rsp_isoc, rsp_overtake, p2p_ack, nop_valid, nop_isoc, pri_claim;
  logic cpl_isoc, sec_ready, fwd_valid, fwd_posted, fwd_isoc, flush_valid;
  logic flush_rsp, write_visible_out;
  int bad_count = 0;
  int n_tests = 0;

  cdob_bridge i_cdob_bridge (.clk, .reset_n, .ppw_all_mode, .np_all_default,
    .func_header, .end_of_chain, .rng_base, .rng_limit, .rng_en, .leg_base,
    .leg_limit, .sec_base, .sec_limit, .hreq_valid, .hreq_addr, .hreq_posted,
    .hreq_isoc, .hreq_seq, .hreq_ready, .dreq_valid, .dreq_addr,
    .dreq_default_route, .dreq_posted, .dreq_isoc, .dreq_seq_tag, .dcpl_valid,
    .dcpl_legacy, .drsp_valid, .drsp_ppw, .drsp_isoc, .posted_stalled,
    .rsp_valid, .pass_posted_write_flag, .rsp_isoc, .rsp_overtake, .p2p_valid,
    .p2p_ack, .nop_req, .nop_valid, .nop_isoc, .pri_valid, .pri_addr,
    .pri_default_route, .pri_nonposted, .pri_isoc, .pri_cfg, .pri_cfg_bus,
    .pri_claim, .cpl_isoc, .sec_valid, .sec_addr, .sec_posted, .sec_isoc,
    .sec_from_legacy, .sec_ready, .fwd_valid, .fwd_addr, .fwd_posted,
    .fwd_isoc, .flush_valid, .flush_rsp, .write_visible_out);

  cdob_partner i_cdob_partner (.clk, .reset_n, .slow, .dreq_valid,
    .dreq_posted, .dreq_default_route, .dreq_addr, .leg_base, .leg_limit,
    .flush_valid, .dcpl_valid, .dcpl_legacy, .flush_rsp);

  always #12.5 clk = ~clk;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(logic [AW-1:0] got, logic [AW-1:0] exp, string m);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // bounded wait on a level; a hang ends the run
  task automatic wait_hi(ref logic s, input int lim, input string m);
    int k;
    k = 0;
    while (s !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (s !== 1'b1) begin
      chk(1'b0, 1'b1, m);
      summarize();
    end
  endtask : wait_hi

  task automatic host(logic [AW-1:0] a, logic p, logic i, logic [3:0] s,
                      logic dr_chk);
    logic hit, leg, edr, enp;
    hit = 0;
    for (int r = 0; r < cdob_pkg::RANGES; r++) begin
      if (a >= rng_base[r*AW+:AW] && a <= rng_limit[r*AW+:AW]) hit = 1;
    end
    leg = a >= leg_base && a <= leg_limit;
    edr = !hit && !leg;
    enp = !p || (np_all_default ? edr : leg);
    hreq_valid <= 1;
    hreq_addr <= a;
    hreq_posted <= p;
    hreq_isoc <= i;
    hreq_seq <= s;
    @(posedge clk);
    wait_hi(hreq_ready, 40, "host take");
    hreq_valid <= 0;
    @(posedge clk);
    chk(dreq_valid, 1, "dreq valid");
    chk(dreq_addr, a, "dreq addr");
    if (dr_chk) chk(dreq_default_route, edr, "default route");
    chk(dreq_posted, !enp, "posted channel");
    chk(dreq_isoc, i, "isoc kept");
    chk(dreq_seq_tag, (leg || edr) ? 4'h0 : s, "seq tag");
  endtask : host

  task automatic pri(logic [AW-1:0] a, logic dr, logic cfg, logic [7:0] bus,
                     logic i, logic exp);
    pri_valid <= 1;
    pri_addr <= a;
    pri_default_route <= dr;
    pri_nonposted <= 1;
    pri_isoc <= i;
    pri_cfg <= cfg;
    pri_cfg_bus <= bus;
    @(posedge clk);
    pri_valid <= 0;
    @(posedge clk);
    chk(pri_claim, exp, "claim");
    chk(cpl_isoc, i, "completion isoc");
  endtask : pri

  task automatic sec(logic [AW-1:0] a, logic p, logic i, logic l, logic e);
    sec_valid <= 1;
    sec_addr <= a;
    sec_posted <= p;
    sec_isoc <= i;
    sec_from_legacy <= l;
    @(posedge clk);
    wait_hi(sec_ready, 50, "secondary take");
    sec_valid <= 0;
    @(posedge clk);
    chk(fwd_valid, e, "forward");
    if (e) chk(fwd_addr, a, "fwd addr");
    if (e) chk({fwd_posted, fwd_isoc}, {p, i}, "fwd kind");
    chk(flush_valid, l && p, "flush issued");
    if (l && p) chk(write_visible_out, 0, "visible drops");
  endtask : sec

  task automatic decode();
    for (int r = 0; r < cdob_pkg::RANGES; r++) begin
      host(rng_base[r*AW+:AW] + 40'h10, 1, r[0], 4'h3, 1);
    end
    host(40'h5000000000, 1, 1, 4'h7, 1);
    host(leg_base + 40'h4, 1, 0, 4'h7, 0);
  endtask : decode

  task automatic legacy_order();
    slow <= 1;
    np_all_default <= 1;
    // let the mode settle before host reads it for its expectation
    @(posedge clk);
    // two others may stand together; legacy then waits for both
    host(rng_base[0+:AW] + 40'h20, 0, 1, 4'h2, 1);
    host(rng_base[AW+:AW] + 40'h20, 0, 0, 4'h6, 1);
    host(40'h6000000000, 1, 0, 4'h5, 1);
    p2p_valid <= 1;
    @(posedge clk);
    p2p_valid <= 0;
    chk(hreq_ready, 0, "legacy blocks");
    @(posedge clk);
    chk(p2p_ack, 1, "peer serviced");
    chk(hreq_ready, 0, "legacy blocks");
    wait_hi(hreq_ready, 30, "legacy done");
    slow <= 0;
  endtask : legacy_order

  task automatic responses();
    for (int m = 0; m < 16; m++) begin
      drsp_valid <= 1;
      drsp_ppw <= m[0];
      drsp_isoc <= m[1];
      posted_stalled <= m[2];
      ppw_all_mode <= m[3];
      @(posedge clk);
      drsp_valid <= 0;
      @(posedge clk);
      chk(rsp_valid, 1, "rsp valid");
      chk(pass_posted_write_flag, m[0] | m[3], "pass flag");
      chk(rsp_isoc, m[1], "rsp isoc");
      chk(rsp_overtake, m[2] & (m[0] | m[3]), "overtake");
    end
    nop_req <= 1;
    @(posedge clk);
    nop_req <= 0;
    @(posedge clk);
    chk({nop_valid, nop_isoc}, 2'b10, "nop");
  endtask : responses

  task automatic bridge_side();
    pri(40'h0, 1, 0, 8'h00, 1, 1);
    pri(40'h123, 0, 0, 8'h00, 0, 0);
    pri(40'h0, 0, 1, 8'h00, 1, 0);
    sec(40'h1800, 1, 0, 0, 0);
    sec(40'h3000, 1, 1, 0, 1);
    func_header <= 1;
    pri(40'h0, 0, 1, 8'h00, 1, 1);
    pri(40'h0, 0, 1, 8'h01, 0, 0);
    sec(40'h1800, 0, 1, 0, 1);
    sec(40'h3000, 1, 0, 1, 1);
    wait_hi(write_visible_out, 20, "visible back");
    end_of_chain <= 1;
    pri(40'h123, 0, 0, 8'h00, 0, 1);
    slow <= 1;
    for (int j = 0; j < 6; j++) sec(40'h3000 + j, 1, 0, 1, 1);
    @(posedge clk);
    chk({sec_ready, write_visible_out}, 2'b00, "six flushes");
    wait_hi(write_visible_out, 300, "all flushed");
  endtask : bridge_side

  initial begin
    for (int r = 0; r < cdob_pkg::RANGES; r++) begin
      rng_base[r*AW+:AW] = 40'(r + 1) << 32;
      rng_limit[r*AW+:AW] = (40'(r + 1) << 32) + 40'hffff;
    end
    repeat (10) @(posedge clk);
    reset_n <= 1;
    repeat (5) @(posedge clk);
    chk({hreq_ready, sec_ready, write_visible_out}, 3'b111, "reset");
    decode();
    legacy_order();
    responses();
    bridge_side();
    summarize();
  end
endmodule : testbench
